// ===== design/ftd_ctrl.sv
`timescale 1ns/1ns
module ftd_ctrl #(
    parameter int unsigned PCT_W = 8,
    parameter int unsigned CUR_W = 16,
    parameter int unsigned FLOW_W = 16
) (
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    input  wire ftd_pkg::ftd_axi_req_t  axi_req,
    output ftd_pkg::ftd_axi_rsp_t       axi_rsp,
    input  wire logic                   key_cfg_pin,
    input  wire logic                   key_back_pin,
    input  wire logic                   key_enter_pin,
    input  wire logic                   key_next_pin,
    input  wire logic                   hart_busy_pin,
    input  wire logic                   board_link_busy_pin,
    input  wire logic                   fwd_vol_tick,
    input  wire logic                   rev_vol_tick,
    input  wire logic                   flow_reverse,
    input  wire logic [FLOW_W-1:0]      flow_rate,
    input  wire logic [PCT_W-1:0]       pct_mag,
    input  wire logic [1:0]             active_range,
    input  wire logic [CUR_W-1:0]       meas_current,
    input  wire logic [CUR_W-1:0]       sim_current,
    input  wire logic [1:0]             do_in,
    output ftd_pkg::ftd_line_t          first_display_item,
    output ftd_pkg::ftd_line_t          second_display_item,
    output logic [2:0]                  range_shown,
    output logic                        pct_neg,
    output logic [PCT_W-1:0]            pct_shown,
    output logic [PCT_W-1:0]            bar_shown,
    output logic                        comm_mark,
    output logic [CUR_W-1:0]            current_out,
    output logic [1:0]                  do_out,
    output ftd_pkg::ftd_mode_t          mode_out
);

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic                 aw_rdy;
        logic                 b_vld;
        logic [1:0]           b_resp;
        logic                 ar_rdy;
        logic                 r_vld;
        logic [31:0]          r_data;
        logic [1:0]           r_resp;
        logic [31:0]          ctrl;
        logic [31:0]          rate;
        ftd_pkg::ftd_mode_t   mode;
        logic [1:0]           cursor;
        logic [5:0]           sync1;
        logic [5:0]           sync2;
        logic [3:0]           key_prev;
        logic [15:0]          fwd_acc;
        logic [15:0]          rev_acc;
        logic [26:0]          fwd;
        logic [26:0]          backward_label;
        ftd_pkg::ftd_line_t   line1;
        ftd_pkg::ftd_line_t   line2;
        logic [2:0]           range;
        logic                 pneg;
        logic [PCT_W-1:0]     pct;
        logic [PCT_W-1:0]     bar;
        logic                 mark;
        logic [CUR_W-1:0]     cur;
        logic [1:0]           dout;
    } ftd_state_t;

    ftd_state_t  st;
    ftd_state_t  next_st;
    logic [3:0]  key_press;
    logic [27:0] diff;
    logic        diff_neg;
    logic [26:0] diff_mag;
    logic        wr_go;
    logic        rd_go;
    logic [31:0] status_word;

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // Returns {count, accumulator}; a zero rate is treated as one
    function automatic logic [42:0] bump(input logic [26:0] cnt, input logic [15:0] acc,
                                         input logic tick, input logic [15:0] quantum);
        logic [15:0] acc_n;
        logic [26:0] cnt_n;
        acc_n = acc;
        cnt_n = cnt;
        if (tick) begin
            if (acc + 16'h0001 >= quantum) begin
                acc_n = 16'h0000;
                cnt_n = (cnt >= ftd_pkg::TOTAL_MAX) ? 27'h0000000 : cnt + 27'h0000001;
            end else begin
                acc_n = acc + 16'h0001;
            end
        end
        return {cnt_n, acc_n};
    endfunction

    function automatic ftd_pkg::ftd_line_t fmt_count(input ftd_pkg::ftd_item_t item,
                                                     input logic [26:0] cnt, input logic neg,
                                                     input logic [31:0] rate);
        ftd_pkg::ftd_line_t ln;
        logic [2:0]  dec;
        logic [1:0]  mexp;
        logic [36:0] scaled;
        ln = '0;
        dec = rate[ftd_pkg::RATE_DEC_LSB +: 3];
        mexp = rate[ftd_pkg::RATE_MEXP_LSB +: 2];
        scaled = 37'h0000000000;
        ln.item = item;
        ln.neg = neg;
        if (dec != 3'h0) begin
            // The point takes one of the eight places, so an eighth digit
            // pushes the point right and the finest digit drops off
            if (cnt >= ftd_pkg::SEVEN_DIGIT) begin
                ln.value = cnt / 27'h000000a;
                ln.point = dec - 3'h1;
            end else begin
                ln.value = cnt;
                ln.point = dec;
            end
        end else begin
            case (mexp)
                2'h0: scaled = {10'h000, cnt};
                2'h1: scaled = {10'h000, cnt} * 37'h000000000a;
                2'h2: scaled = {10'h000, cnt} * 37'h0000000064;
                default: scaled = {10'h000, cnt} * 37'h00000003e8;
            endcase
            if (scaled > {10'h000, ftd_pkg::TOTAL_MAX}) begin
                ln.error = 1'b1;
                ln.value = ftd_pkg::TOTAL_MAX;
            end else begin
                ln.value = scaled[26:0];
            end
        end
        return ln;
    endfunction

    function automatic ftd_pkg::ftd_line_t fmt_line(input logic [2:0] code);
        ftd_pkg::ftd_line_t ln;
        ln = '0;
        case (ftd_pkg::ftd_item_t'(code))
            ftd_pkg::ITEM_FLOW: begin
                ln.item = ftd_pkg::ITEM_FLOW;
                ln.value = 27'(flow_rate);
                ln.label = flow_reverse ? ftd_pkg::BACKWARD_LABEL
                                        : ftd_pkg::FORWARD_LABEL;
            end
            ftd_pkg::ITEM_PCT: begin
                ln.item = ftd_pkg::ITEM_PCT;
                ln.value = 27'(pct_mag);
                ln.neg = flow_reverse;
            end
            ftd_pkg::ITEM_FWD: ln = fmt_count(ftd_pkg::ITEM_FWD, st.fwd, 1'b0, st.rate);
            ftd_pkg::ITEM_REV: ln = fmt_count(ftd_pkg::ITEM_REV, st.backward_label, 1'b0, st.rate);
            ftd_pkg::ITEM_DIFF: ln = fmt_count(ftd_pkg::ITEM_DIFF, diff_mag, diff_neg,
                                               st.rate);
            ftd_pkg::ITEM_RANGE: begin
                ln.item = ftd_pkg::ITEM_RANGE;
                ln.value = 27'(st.range);
            end
            default: begin
                ln.item = ftd_pkg::ftd_item_t'(code);
                ln.error = 1'b1;
            end
        endcase
        return ln;
    endfunction

    // ************************************************************
    // Derived values
    // ************************************************************
    // Plain binary subtraction; once forward has wrapped to zero the difference reads negative
    assign diff = {1'b0, st.fwd} - {1'b0, st.backward_label};
    assign diff_neg = diff[27];
    assign diff_mag = diff_neg ? 27'(-diff) : diff[26:0];
    assign key_press = st.sync2[3:0] & ~st.key_prev;
    assign wr_go = st.aw_rdy & axi_req.awvalid & axi_req.wvalid;
    assign rd_go = st.ar_rdy & axi_req.arvalid;
    assign status_word = {24'h000000, st.mark, flow_reverse, st.range[1:0] - 2'h1,
                          1'b0, st.mode};

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        next_st = st;
        next_st.sync1 = {board_link_busy_pin, hart_busy_pin,
                         key_next_pin, key_enter_pin, key_back_pin, key_cfg_pin};
        next_st.sync2 = st.sync1;
        next_st.key_prev = st.sync2[3:0];

        // Operator keys walk the mode machine
        case (st.mode)
            ftd_pkg::MODE_MEAS: begin
                if (key_press[ftd_pkg::KEY_CFG]) begin
                    next_st.mode = ftd_pkg::MODE_MENU;
                    next_st.cursor = 2'h0;
                end
            end
            ftd_pkg::MODE_MENU: begin
                if (key_press[ftd_pkg::KEY_BACK]) begin
                    next_st.mode = ftd_pkg::MODE_MEAS;
                end else if (key_press[ftd_pkg::KEY_NEXT]) begin
                    next_st.cursor = (st.cursor == ftd_pkg::MENU_LAST) ? 2'h0
                                                                        : st.cursor + 2'h1;
                end else if (key_press[ftd_pkg::KEY_ENTER]) begin
                    case (st.cursor)
                        2'h0: next_st.mode = ftd_pkg::MODE_SET;
                        2'h1: next_st.mode = ftd_pkg::MODE_CAL;
                        default: next_st.mode = ftd_pkg::MODE_PLS_DO;
                    endcase
                end
            end
            ftd_pkg::MODE_SET, ftd_pkg::MODE_CAL: begin
                if (key_press[ftd_pkg::KEY_BACK]) begin
                    next_st.mode = ftd_pkg::MODE_MEAS;
                end
            end
            ftd_pkg::MODE_PLS_DO: begin
                // Each choice is stored at once so an abort keeps it
                if (key_press[ftd_pkg::KEY_BACK]) begin
                    next_st.mode = ftd_pkg::MODE_MEAS;
                end else if (key_press[ftd_pkg::KEY_NEXT]) begin
                    case (st.ctrl[ftd_pkg::CTRL_DO1_LSB +: 2])
                        ftd_pkg::COMBINED_PULSE_FUNCTION:
                            next_st.ctrl[ftd_pkg::CTRL_DO1_LSB +: 2] =
                                ftd_pkg::FORWARD_PULSE_FUNCTION;
                        ftd_pkg::FORWARD_PULSE_FUNCTION:
                            next_st.ctrl[ftd_pkg::CTRL_DO1_LSB +: 2] =
                                ftd_pkg::BACKWARD_PULSE_FUNCTION;
                        default:
                            next_st.ctrl[ftd_pkg::CTRL_DO1_LSB +: 2] =
                                ftd_pkg::COMBINED_PULSE_FUNCTION;
                    endcase
                end else if (key_press[ftd_pkg::KEY_ENTER]) begin
                    next_st.mode = ftd_pkg::MODE_PLS_RATE;
                end
            end
            ftd_pkg::MODE_PLS_RATE: begin
                if (key_press[ftd_pkg::KEY_BACK]) begin
                    next_st.mode = ftd_pkg::MODE_MEAS;
                end else if (key_press[ftd_pkg::KEY_ENTER]) begin
                    next_st.mode = st.ctrl[ftd_pkg::CTRL_WMANUAL] ? ftd_pkg::MODE_PLS_WIDTH
                                                                  : ftd_pkg::MODE_PLS_CNT;
                end
            end
            ftd_pkg::MODE_PLS_WIDTH: begin
                if (key_press[ftd_pkg::KEY_BACK]) begin
                    next_st.mode = ftd_pkg::MODE_MEAS;
                end else if (key_press[ftd_pkg::KEY_ENTER]) begin
                    next_st.mode = ftd_pkg::MODE_PLS_CNT;
                end
            end
            ftd_pkg::MODE_PLS_CNT: begin
                if (key_press[ftd_pkg::KEY_BACK]) begin
                    next_st.mode = ftd_pkg::MODE_MEAS;
                end else if (key_press[ftd_pkg::KEY_ENTER]) begin
                    next_st.ctrl[ftd_pkg::CTRL_RUN] = 1'b1;
                end
            end
            default: next_st.mode = ftd_pkg::MODE_MEAS;
        endcase

        // ********************************************************
        // Bus write; a bus write to CTRL wins over a key in the same cycle
        // ********************************************************
        if (wr_go) begin
            next_st.aw_rdy = 1'b0;
            next_st.b_vld = 1'b1;
            next_st.b_resp = ftd_pkg::RESP_OKAY;
            case ({axi_req.awaddr[7:2], 2'b00})
                ftd_pkg::OFF_CTRL:
                    next_st.ctrl = merge(next_st.ctrl, axi_req.wdata, axi_req.wstrb)
                                   & ftd_pkg::CTRL_MASK;
                ftd_pkg::OFF_RATE:
                    next_st.rate = merge(st.rate, axi_req.wdata, axi_req.wstrb)
                                   & ftd_pkg::RATE_MASK;
                ftd_pkg::OFF_STATUS, ftd_pkg::OFF_FWD, ftd_pkg::OFF_REV,
                ftd_pkg::OFF_DIFF: ;
                default: next_st.b_resp = ftd_pkg::RESP_SLVERR;
            endcase
        end else if (!st.aw_rdy && !st.b_vld && axi_req.awvalid && axi_req.wvalid) begin
            next_st.aw_rdy = 1'b1;
        end
        if (st.b_vld && axi_req.bready) begin
            next_st.b_vld = 1'b0;
        end

        // Bus read
        if (rd_go) begin
            next_st.ar_rdy = 1'b0;
            next_st.r_vld = 1'b1;
            next_st.r_resp = ftd_pkg::RESP_OKAY;
            case ({axi_req.araddr[7:2], 2'b00})
                ftd_pkg::OFF_CTRL:   next_st.r_data = st.ctrl;
                ftd_pkg::OFF_RATE:   next_st.r_data = st.rate;
                ftd_pkg::OFF_STATUS: next_st.r_data = status_word;
                ftd_pkg::OFF_FWD:    next_st.r_data = {5'h00, st.fwd};
                ftd_pkg::OFF_REV:    next_st.r_data = {5'h00, st.backward_label};
                ftd_pkg::OFF_DIFF:   next_st.r_data = {{4{diff[27]}}, diff};
                default: begin
                    next_st.r_data = 32'h0000_0000;
                    next_st.r_resp = ftd_pkg::RESP_SLVERR;
                end
            endcase
        end else if (!st.ar_rdy && !st.r_vld && axi_req.arvalid) begin
            next_st.ar_rdy = 1'b1;
        end
        if (st.r_vld && axi_req.rready) begin
            next_st.r_vld = 1'b0;
        end

        // ********************************************************
        // Totalizers: a clear in the same cycle as a tick clears first, then that tick counts
        // ********************************************************
        if (wr_go && {axi_req.awaddr[7:2], 2'b00} == ftd_pkg::OFF_CTRL
            && axi_req.wstrb[2] && axi_req.wdata[ftd_pkg::CTRL_CLEAR]) begin
            next_st.fwd = 27'h0000000;
            next_st.backward_label = 27'h0000000;
            next_st.fwd_acc = 16'h0000;
            next_st.rev_acc = 16'h0000;
        end
        {next_st.fwd, next_st.fwd_acc} = bump(next_st.fwd, next_st.fwd_acc,
            fwd_vol_tick & st.ctrl[ftd_pkg::CTRL_RUN], st.rate[15:0]);
        {next_st.backward_label, next_st.rev_acc} = bump(next_st.backward_label, next_st.rev_acc,
            rev_vol_tick & st.ctrl[ftd_pkg::CTRL_RUN], st.rate[15:0]);

        // ********************************************************
        // Display and outputs
        // ********************************************************
        next_st.line1 = fmt_line(st.ctrl[ftd_pkg::CTRL_ITEM1_LSB +: 3]);
        next_st.line2 = fmt_line(st.ctrl[ftd_pkg::CTRL_ITEM2_LSB +: 3]);
        next_st.range = st.ctrl[ftd_pkg::CTRL_MULTI]
                        ? {1'b0, active_range} + 3'h1
                        : {1'b0, st.ctrl[ftd_pkg::CTRL_RANGE_LSB +: 2]} + 3'h1;
        next_st.pneg = flow_reverse;
        next_st.pct = pct_mag;
        next_st.bar = flow_reverse ? '0 : pct_mag;
        next_st.mark = st.sync2[4] | st.sync2[5];
        if (st.mode == ftd_pkg::MODE_CAL) begin
            next_st.cur = sim_current;
        end else begin
            next_st.cur = meas_current;
            next_st.dout = do_in;
        end
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '0;
            st.ctrl <= ftd_pkg::CTRL_RST;
            st.rate <= ftd_pkg::RATE_RST;
            st.mode <= ftd_pkg::MODE_MEAS;
        end else begin
            st <= next_st;
        end
    end

    assign axi_rsp.awready = st.aw_rdy;
    assign axi_rsp.wready = st.aw_rdy;
    assign axi_rsp.bvalid = st.b_vld;
    assign axi_rsp.bresp = st.b_resp;
    assign axi_rsp.arready = st.ar_rdy;
    assign axi_rsp.rvalid = st.r_vld;
    assign axi_rsp.rdata = st.r_data;
    assign axi_rsp.rresp = st.r_resp;
    assign first_display_item = st.line1;
    assign second_display_item = st.line2;
    assign range_shown = st.range;
    assign pct_neg = st.pneg;
    assign pct_shown = st.pct;
    assign bar_shown = st.bar;
    assign comm_mark = st.mark;
    assign current_out = st.cur;
    assign do_out = st.dout;
    assign mode_out = st.mode;

endmodule

// ===== include/ftd_pkg.sv
package ftd_pkg;

    // ************************************************************
    // Register map (byte addresses)
    // ************************************************************
    localparam logic [7:0]  OFF_CTRL   = 8'h00;
    localparam logic [7:0]  OFF_RATE   = 8'h04;
    localparam logic [7:0]  OFF_STATUS = 8'h08;
    localparam logic [7:0]  OFF_FWD    = 8'h0c;
    localparam logic [7:0]  OFF_REV    = 8'h10;
    localparam logic [7:0]  OFF_DIFF   = 8'h14;

    // ************************************************************
    // Field positions and reset values
    // ************************************************************
    localparam int          CTRL_ITEM1_LSB = 0;
    localparam int          CTRL_ITEM2_LSB = 4;
    localparam int          CTRL_MULTI     = 8;
    localparam int          CTRL_RANGE_LSB = 9;
    localparam int          CTRL_WMANUAL   = 12;
    localparam int          CTRL_RUN       = 13;
    localparam int          CTRL_CLEAR     = 16;
    localparam int          CTRL_DO1_LSB   = 24;
    localparam logic [31:0] CTRL_MASK      = 32'h0300_377f;
    localparam logic [31:0] CTRL_RST       = 32'h0000_2020;
    localparam int          RATE_DEC_LSB   = 16;
    localparam int          RATE_MEXP_LSB  = 20;
    localparam logic [31:0] RATE_MASK      = 32'h0037_ffff;
    localparam logic [31:0] RATE_RST       = 32'h0000_0001;

    // ************************************************************
    // Counting limits
    // ************************************************************
    localparam logic [26:0] TOTAL_MAX   = 27'h5f5e0ff;
    localparam logic [26:0] SEVEN_DIGIT = 27'h0989680;
    localparam logic [1:0]  MENU_LAST   = 2'h2;

    // Key bit positions in the key vector
    localparam int          KEY_CFG   = 0;
    localparam int          KEY_BACK  = 1;
    localparam int          KEY_ENTER = 2;
    localparam int          KEY_NEXT  = 3;

    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        ITEM_FLOW, ITEM_PCT, ITEM_FWD, ITEM_REV, ITEM_DIFF, ITEM_RANGE
    } ftd_item_t;

    typedef enum logic [2:0] {
        MODE_MEAS, MODE_MENU, MODE_SET, MODE_CAL,
        MODE_PLS_DO, MODE_PLS_RATE, MODE_PLS_WIDTH, MODE_PLS_CNT
    } ftd_mode_t;

    typedef enum logic [1:0] {
        COMBINED_PULSE_FUNCTION, FORWARD_PULSE_FUNCTION, BACKWARD_PULSE_FUNCTION
    } ftd_pulse_fn_t;

    typedef enum logic [1:0] {
        LABEL_NONE, FORWARD_LABEL, BACKWARD_LABEL
    } ftd_label_t;

    typedef struct packed {
        ftd_item_t   item;
        ftd_label_t  label;
        logic        neg;
        logic [26:0] value;
        logic [2:0]  point;
        logic        error;
    } ftd_line_t;

    typedef struct packed {
        logic [7:0]  awaddr;
        logic        awvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        wvalid;
        logic        bready;
        logic [7:0]  araddr;
        logic        arvalid;
        logic        rready;
    } ftd_axi_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic [1:0]  bresp;
        logic        bvalid;
        logic        arready;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic        rvalid;
    } ftd_axi_rsp_t;

endpackage

// ===== testbench/ftd_checker.sv
`timescale 1ns/1ns
module ftd_checker #(
    parameter int unsigned PCT_W = 8,
    parameter int unsigned CUR_W = 16
) (
    input wire logic               aclk,
    input wire logic               aresetn,
    input wire logic               flow_reverse,
    input wire logic               hart_busy_pin,
    input wire logic               board_link_busy_pin,
    input wire logic               key_cfg_pin,
    input wire logic               key_back_pin,
    input wire logic [CUR_W-1:0]   meas_current,
    input wire logic [CUR_W-1:0]   sim_current,
    input wire ftd_pkg::ftd_line_t first_display_item,
    input wire logic [2:0]         range_shown,
    input wire logic [PCT_W-1:0]   bar_shown,
    input wire logic               comm_mark,
    input wire logic [CUR_W-1:0]   current_out,
    input wire logic [1:0]         do_out,
    input wire ftd_pkg::ftd_mode_t mode_out
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    chk_flow_label: assert property (
        ($stable(flow_reverse) && first_display_item.item == 3'h0)[*3]
        |-> first_display_item.label == (flow_reverse ? 2'h2 : 2'h1)) else $error("flow label");
    chk_bar_reverse: assert property (flow_reverse[*3] |-> bar_shown == '0)
        else $error("bar not zero");
    chk_comm_mark: assert property ($stable(hart_busy_pin || board_link_busy_pin)[*4]
        |-> comm_mark == (hart_busy_pin || board_link_busy_pin)) else $error("comm mark");
    chk_range_shown: assert property ($past(aresetn) |-> range_shown inside {[3'h1:3'h4]})
        else $error("range out of 1..4");
    chk_cal_freeze: assert property ($past(mode_out) == ftd_pkg::MODE_CAL
        |-> $stable(do_out) && current_out == $past(sim_current)) else $error("cal outputs");
    chk_meas_track: assert property ($past(aresetn)
        && $past(mode_out) inside {ftd_pkg::MODE_MEAS, ftd_pkg::MODE_SET}
        |-> current_out == $past(meas_current)) else $error("current not tracking");
    chk_cfg_menu: assert property ($rose(key_cfg_pin) && mode_out == ftd_pkg::MODE_MEAS
        |-> ##4 mode_out == ftd_pkg::MODE_MENU) else $error("cfg key");
    chk_back_meas: assert property ($rose(key_back_pin) && mode_out != ftd_pkg::MODE_MEAS
        |-> ##4 mode_out == ftd_pkg::MODE_MEAS) else $error("back key");
    cover property (mode_out == ftd_pkg::MODE_CAL);
    cover property (mode_out == ftd_pkg::MODE_PLS_CNT);
    cover property (comm_mark);
endmodule

// ===== testbench/ftd_ctrl_tb.sv
`timescale 1ns/1ns
module ftd_ctrl_tb;
    logic aclk = 0, aresetn = 0, hart_busy_pin = 0, board_link_busy_pin = 0, flow_reverse = 0;
    logic fwd_vol_tick = 0, rev_vol_tick = 0, pct_neg, comm_mark;
    logic [1:0] active_range = 0, do_in = 2'h1, do_out;
    logic [15:0] flow_rate = 16'h0123, meas_current = 16'h0aaa, sim_current = 16'h0555;
    logic [15:0] current_out;
    logic [7:0] pct_mag = 8'h32, pct_shown, bar_shown;
    logic [3:0] key_req = 0, keys;
    logic [2:0] range_shown;
    ftd_pkg::ftd_axi_req_t axi_req = '0;
    ftd_pkg::ftd_axi_rsp_t axi_rsp;
    ftd_pkg::ftd_line_t first_display_item, second_display_item;
    ftd_pkg::ftd_mode_t mode_out;
    int errors = 0, check_count = 0;
    ftd_ctrl dut (.*, .key_cfg_pin(keys[0]), .key_back_pin(keys[1]), .key_enter_pin(keys[2]),
        .key_next_pin(keys[3]));
    ftd_operator op (.aclk(aclk), .key_req(key_req), .keys(keys));
    initial forever #50 aclk = ~aclk;
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            errors++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        axi_req <= '{awaddr:a, awvalid:1, wdata:d, wstrb:4'hf, wvalid:1, bready:1, default:0};
        do @(posedge aclk); while (!axi_rsp.awready);
        axi_req.awvalid <= 0;
        axi_req.wvalid <= 0;
        do @(posedge aclk); while (!axi_rsp.bvalid);
        axi_req.bready <= 0;
        @(posedge aclk);
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
        axi_req <= '{araddr:a, arvalid:1, rready:1, default:0};
        do @(posedge aclk); while (!axi_rsp.arready);
        axi_req.arvalid <= 0;
        do @(posedge aclk); while (!axi_rsp.rvalid);
        chk("rdata", e, axi_rsp.rdata);
        chk("rresp", {30'h0, r}, {30'h0, axi_rsp.rresp});
        axi_req.rready <= 0;
        @(posedge aclk);
    endtask
    task automatic ticks(input int n, input logic backward_label);
        if (backward_label) rev_vol_tick <= 1; else fwd_vol_tick <= 1;
        repeat (n) @(posedge aclk);
        rev_vol_tick <= 0;
        fwd_vol_tick <= 0;
        repeat (4) @(posedge aclk);
    endtask
    // Key sequence packed two bits per key, first key in the low bits
    task automatic keyseq(input logic [15:0] s, input int n, input logic [2:0] m);
        for (int i = 0; i < n; i++) begin
            key_req <= 4'h1 << s[2*i+:2];
            @(posedge aclk);
            key_req <= 0;
            repeat (14) @(posedge aclk);
        end
        chk("mode", {29'h0, m}, {29'h0, mode_out});
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge aclk);
        errors++;
        print_verdict();
    end
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        chk("mode", 0, {29'h0, mode_out});
        rc(ftd_pkg::OFF_CTRL, ftd_pkg::CTRL_RST, 2'h0);
        rc(ftd_pkg::OFF_RATE, ftd_pkg::RATE_RST, 2'h0);
        rc(8'h18, 0, ftd_pkg::RESP_SLVERR);
        $display("end of reset test");
        wr(ftd_pkg::OFF_CTRL, 32'h0000_2040);
        ticks(3, 0);
        ticks(5, 1);
        rc(ftd_pkg::OFF_DIFF, 32'hffff_fffe, 2'h0);
        chk("diff sign", 1, second_display_item.neg);
        ticks(4, 0);
        wr(ftd_pkg::OFF_RATE, 32'h2);
        ticks(5, 0);
        rc(ftd_pkg::OFF_FWD, 32'h9, 2'h0);
        rc(ftd_pkg::OFF_DIFF, 32'h4, 2'h0);
        chk("diff sign", 0, second_display_item.neg);
        $display("end of total test");
        flow_reverse <= 1;
        repeat (4) @(posedge aclk);
        chk("pct sign", 1, pct_neg);
        chk("bar", 0, bar_shown);
        chk("pct", pct_mag, pct_shown);
        flow_reverse <= 0;
        hart_busy_pin <= 1;
        wr(ftd_pkg::OFF_CTRL, 32'h0000_2146);
        active_range <= 2'h2;
        repeat (4) @(posedge aclk);
        chk("item error", 1, first_display_item.error);
        chk("bar", pct_mag, bar_shown);
        chk("range", 3, range_shown);
        chk("comm", 1, comm_mark);
        hart_busy_pin <= 0;
        $display("end of display test");
        keyseq(16'h002c, 3, ftd_pkg::MODE_CAL);
        do_in <= 2'h2;
        repeat (3) @(posedge aclk);
        chk("do frozen", 1, do_out);
        keyseq(16'h0001, 1, ftd_pkg::MODE_MEAS);
        keyseq(16'h2bbc, 7, ftd_pkg::MODE_PLS_CNT);
        keyseq(16'h0001, 1, ftd_pkg::MODE_MEAS);
        rc(ftd_pkg::OFF_CTRL, 32'h0100_2146, 2'h0);
        wr(ftd_pkg::OFF_CTRL, 32'h0100_3146);
        keyseq(16'h0abc, 6, ftd_pkg::MODE_PLS_WIDTH);
        $display("end of mode test");
        print_verdict();
    end
endmodule
bind ftd_ctrl ftd_checker #(.PCT_W(PCT_W), .CUR_W(CUR_W)) chk (.*);

// ===== testbench/ftd_operator.sv
`timescale 1ns/1ns
// ****
// Operator: holds each key a few cycles, then lets go so the edge detect rearms
// ****
module ftd_operator (
    input  wire logic       aclk,
    input  wire logic [3:0] key_req,
    output logic      [3:0] keys = 4'h0
);
    logic [2:0] hold = 3'h0;
    always_ff @(posedge aclk) begin
        if (key_req != 4'h0) begin
            keys <= key_req;
            hold <= 3'h4;
        end else if (hold != 3'h0) begin
            hold <= hold - 3'h1;
        end else begin
            keys <= 4'h0;
        end
    end
endmodule
